// >>> rtl/buck_ctrl_pkg.sv
// Constants shared by the buck regulator control block and its per-regulator slice.
// Assumes a single 100 MHz system clock; no bus, all control bits are ports.
package buck_ctrl_pkg;
  localparam int CODE_W = 6;  // Width of a voltage code
  localparam int STBY_W = 5;  // Width of a standby set point field
  localparam int MODE_W = 2;  // Width of an effective mode code
  // Effective operating modes driven to the power stage
  localparam logic [1:0] MODE_OFF = 2'h0;  // Switched off
  localparam logic [1:0] MODE_PFM = 2'h1;  // Pulse-frequency mode
  localparam logic [1:0] MODE_RUN = 2'h2;  // Normal mode, as chosen elsewhere
  // Voltage mapping: 650.0 mV base, 12.5 mV step, in units of 0.1 mV
  localparam int VBASE_TENTH_MV = 6500;  // Output at code 0
  localparam int VSTEP_TENTH_MV = 125;   // Step per code
  localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;  // Code at reset
  // Clocking: 100 MHz system clock, ramp step time in ns
  localparam int CLK_PERIOD_NS = 10;     // System clock period
  localparam int RAMP_STEP_NS = 2000;    // Time per set-point ramp step
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RAMP_STEP_NS / CLK_PERIOD_NS;  // Longest time, rounded down
  // Switching frequency selection
  localparam int REF_HZ = 32768;         // Crystal reference for the switching PLL
  localparam int FSW_LOW_HZ = 2000000;   // Switching rate with select bit 0
  localparam int FSW_HIGH_HZ = 4000000;  // Switching rate with select bit 1
  localparam int PLL_MULT_LOW = FSW_LOW_HZ / REF_HZ;    // Feedback divide, low rate
  localparam int PLL_MULT_HIGH = FSW_HIGH_HZ / REF_HZ;  // Feedback divide, high rate
  localparam int MULT_W = 8;                            // Width of feedback divide
  // Low power states presented to the block
  localparam logic [1:0] LP_NONE = 2'h0;   // Normal operation
  localparam logic [1:0] LP_HOLD = 2'h1;   // Memory hold
  localparam logic [1:0] LP_UOFF = 2'h2;   // User off
endpackage : buck_ctrl_pkg

// >>> rtl/buck_slice.sv
// One buck regulator's low-power mode, set point selection and voltage ramp.
// Assumes state, slot and code inputs are synchronous to the system clock.
module buck_slice #(
  parameter int RAMP_CYC = buck_ctrl_pkg::RAMP_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lp_state_i,          // Low power state
  input wire logic hold_state_mode_select_i,  // Mode in memory hold
  input wire logic user_off_mode_select_i,    // Mode in user off
  input wire logic [4:0] standby_setpoint_i,  // Standby set point
  input wire logic [5:0] voltage_code_i,      // Normal set point
  input wire logic startup_i,                 // Startup event pulse
  input wire logic slot_i,                    // Sequencer slot pulse
  input wire logic normal_enable_i,           // Regulator enabled in normal mode
  output logic [1:0] mode_o,                  // Effective mode
  output logic [5:0] target_o,                // Ramp target code
  output logic [5:0] applied_o,               // Code on the power stage
  output logic at_target_o                    // Ramp has reached target
);
  // Refuse a ramp step shorter than one clock
  if (RAMP_CYC < 1) begin : g_bad_ramp
    $error("RAMP_CYC must be at least 1");
  end
  localparam int CNT_W = $clog2(RAMP_CYC + 1);
  logic [1:0] mode;          // Held mode
  logic [5:0] target;        // Held target
  logic [5:0] applied;       // Ramp position
  logic [CNT_W-1:0] cnt;     // Ramp step timer
  logic held;                // Frozen after a low power state in PFM until slot
  wire in_lp = (lp_state_i != buck_ctrl_pkg::LP_NONE);
  wire lp_sel = (lp_state_i == buck_ctrl_pkg::LP_HOLD) ? hold_state_mode_select_i :
                user_off_mode_select_i;
  // Low power mode: 0 is off, 1 is PFM
  wire [1:0] lp_mode = lp_sel ? buck_ctrl_pkg::MODE_PFM : buck_ctrl_pkg::MODE_OFF;
  // Active in low power state targets the standby field, widened to code width
  wire [5:0] lp_target = {1'b0, standby_setpoint_i};
  wire [1:0] run_mode = normal_enable_i ? buck_ctrl_pkg::MODE_RUN : buck_ctrl_pkg::MODE_OFF;
  wire step_due = (cnt == CNT_W'(RAMP_CYC - 1));
  // Mode and target selection; frozen after a PFM low power state until this regulator's slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= buck_ctrl_pkg::MODE_OFF;
      target <= buck_ctrl_pkg::CODE_RESET;
      held <= 1'b0;
    end else if (in_lp) begin
      mode <= lp_mode;
      target <= lp_target;
      held <= (lp_mode != buck_ctrl_pkg::MODE_OFF);
    end else if (held && !slot_i) begin
      held <= held;
    end else begin
      // Not held, or slot reached: update without an off step
      mode <= run_mode;
      target <= voltage_code_i;
      held <= 1'b0;
    end
  end
  // Stepped ramp of the applied code toward the target
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied <= buck_ctrl_pkg::CODE_RESET;
      cnt <= '0;
    end else if (applied == target) begin
      cnt <= '0;
    end else if (step_due) begin
      cnt <= '0;
      applied <= (applied < target) ? applied + 6'h01 : applied - 6'h01;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end
  assign mode_o = mode;
  assign target_o = target;
  assign applied_o = applied;
  // Drops in the cycle a differing target is loaded
  assign at_target_o = (applied == target);
  wire unused = startup_i;
endmodule : buck_slice

// >>> rtl/buck_regulator_control.sv
// Top of the buck regulator control for the core and second regulators.
// Assumes control bits come from a register file on the system clock; pins are asynchronous.
module buck_regulator_control #(
  parameter int RAMP_CYC = buck_ctrl_pkg::RAMP_STEP_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [1:0] LP_STATE_I,             // Low power state
  input wire logic STARTUP_I,                    // Startup event pulse
  input wire logic CORE_SLOT_I,                  // Core sequencer slot pulse
  input wire logic SECOND_SLOT_I,                // Second buck sequencer slot pulse
  input wire logic CORE_ENABLE_I,                // Core enabled in normal mode
  input wire logic SECOND_ENABLE_I,              // Second enabled in normal mode
  input wire logic [1:0] HOLD_STATE_MODE_SELECT_I, // Per regulator, bit 0 core
  input wire logic [1:0] USER_OFF_MODE_SELECT_I,   // Per regulator, bit 0 core
  input wire logic [4:0] CORE_STANDBY_SETPOINT_I,
  input wire logic [4:0] SECOND_STANDBY_SETPOINT_I,
  input wire logic [5:0] CORE_VOLTAGE_CODE_I,
  input wire logic [5:0] SECOND_BUCK_VOLTAGE_CODE_I,
  input wire logic SWITCH_FREQ_SELECT_I,
  input wire logic PLL_KEEP_RUNNING_I,
  input wire logic CORE_PHASE_CONFIG_PIN_I,      // Asynchronous strap pin
  input wire logic CORE_OC_I,                    // Asynchronous core over-current detect
  input wire logic SECOND_OC_I,                  // Asynchronous second over-current detect
  input wire logic CORE_FLAG_CLEAR_I,            // Clear pulse, core flag
  input wire logic SECOND_FLAG_CLEAR_I,          // Clear pulse, second flag
  output logic [1:0] CORE_MODE_O,
  output logic [1:0] SECOND_MODE_O,
  output logic [5:0] CORE_A_CODE_O,              // Phase A code
  output logic [5:0] CORE_B_CODE_O,              // Phase B code
  output logic [5:0] SECOND_CODE_O,
  output logic [15:0] CORE_MV10_O,               // Core output in 0.1 mV
  output logic [15:0] SECOND_MV10_O,             // Second output in 0.1 mV
  output logic CORE_POWER_GOOD_O,
  output logic CORE_SINGLE_PHASE_O,
  output logic PLL_RUN_O,
  output logic [7:0] PLL_MULT_O,                 // PLL feedback divide
  output logic CORE_CYCLE_LIMIT_O,
  output logic SECOND_CYCLE_LIMIT_O,
  output logic CORE_OVERCURRENT_FLAG_O,
  output logic SECOND_BUCK_OVERCURRENT_FLAG_O,
  output logic SHORT_CIRCUIT_IRQ_O
);
  // Refuse a ramp step shorter than one clock: the step timer needs a count of one or more
  if (RAMP_CYC < 1) begin : g_bad_ramp
    $error("RAMP_CYC must be at least 1");
  end

  // Code to output voltage in tenths of a millivolt
  // Linear map: base at code 0, one fixed step per code, so no table is kept
  // Worst case is code 63, which still fits the 16-bit result
  function automatic logic [15:0] code_to_mv10(input logic [5:0] code);
    code_to_mv10 = 16'(buck_ctrl_pkg::VBASE_TENTH_MV) +
                   16'(32'(code) * buck_ctrl_pkg::VSTEP_TENTH_MV);
  endfunction : code_to_mv10

  // Next value of a sticky fault flag; a new event wins over a clear
  // Keeping the set term outside the clear means an event that lands in the
  // clearing cycle is never lost, so the interrupt source can still be found
  function automatic logic sticky_next(input logic event_seen, input logic flag,
                                       input logic clear);
    sticky_next = event_seen | (flag & ~clear);
  endfunction : sticky_next

  // Signals shared between the two slices and the output stage
  logic [5:0] core_target;     // Core ramp target
  logic [5:0] core_applied;    // Core ramp position
  logic [5:0] second_applied;  // Second ramp position
  logic core_at;               // Core at target
  logic [1:0] core_mode;       // Core effective mode
  logic [1:0] second_mode;     // Second effective mode
  // Core regulator slice
  // Both core phases share this one slice, so they can never disagree on the code
  // Low power state, slot and enable come from logic on this clock: no synchroniser
  buck_slice #(.RAMP_CYC(RAMP_CYC)) u_core (
    .clk_i(SYS_CLK_I), .rst_i(RESET_I), .lp_state_i(LP_STATE_I),
    .hold_state_mode_select_i(HOLD_STATE_MODE_SELECT_I[0]),
    .user_off_mode_select_i(USER_OFF_MODE_SELECT_I[0]),
    .standby_setpoint_i(CORE_STANDBY_SETPOINT_I),
    .voltage_code_i(CORE_VOLTAGE_CODE_I), .startup_i(STARTUP_I),
    .slot_i(CORE_SLOT_I), .normal_enable_i(CORE_ENABLE_I),
    .mode_o(core_mode), .target_o(core_target), .applied_o(core_applied),
    .at_target_o(core_at)
  );
  // Second buck slice
  // Its target and at-target outputs are not needed: only the core has power good
  buck_slice #(.RAMP_CYC(RAMP_CYC)) u_second (
    .clk_i(SYS_CLK_I), .rst_i(RESET_I), .lp_state_i(LP_STATE_I),
    .hold_state_mode_select_i(HOLD_STATE_MODE_SELECT_I[1]),
    .user_off_mode_select_i(USER_OFF_MODE_SELECT_I[1]),
    .standby_setpoint_i(SECOND_STANDBY_SETPOINT_I),
    .voltage_code_i(SECOND_BUCK_VOLTAGE_CODE_I), .startup_i(STARTUP_I),
    .slot_i(SECOND_SLOT_I), .normal_enable_i(SECOND_ENABLE_I),
    .mode_o(second_mode), .target_o(), .applied_o(second_applied),
    .at_target_o()
  );

  // Pin synchronisers; stage 1 feeds only stage 2
  // The detect pins come from the analog stage with no relation to the clock
  // Reset clears both stages, so the settled values read low for two cycles
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {SECOND_OC_I, CORE_OC_I, CORE_PHASE_CONFIG_PIN_I};
      pin_s2 <= pin_s1;
    end
  end
  // Settled pin values, two cycles behind the pins
  wire phase_pin = pin_s2[0];
  wire core_oc = pin_s2[1];
  wire second_oc = pin_s2[2];

  // Phase strap captured on each startup event only
  // Taking it straight after reset would read the synchroniser's reset value, not
  // the pin, and report dual phase on a board strapped for single phase
  // Until the first startup event the reset value, single phase, stands
  logic single_phase; // Captured phase configuration, 1 is single phase
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      single_phase <= 1'b1;
    end else if (STARTUP_I) begin
      single_phase <= phase_pin;
    end
  end

  // Sticky fault flags; a new event wins over a clear
  logic core_flag; // Core over-current seen since the last clear
  logic second_flag; // Second over-current seen since the last clear
  wire next_core_flag = sticky_next(core_oc, core_flag, CORE_FLAG_CLEAR_I);
  wire next_second_flag = sticky_next(second_oc, second_flag, SECOND_FLAG_CLEAR_I);
  // Flags update every cycle; reset, or a clear pulse with no new event, forces them low
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      core_flag <= 1'b0;
      second_flag <= 1'b0;
    end else begin
      core_flag <= next_core_flag;
      second_flag <= next_second_flag;
    end
  end

  // Registered outputs
  // Every data output but the shared interrupt leaves from a flip-flop so those pins never see decode glitches
  logic power_good; // Core set point reached
  logic pll_run; // Switching PLL enabled
  logic [7:0] pll_mult; // Feedback divide in use
  logic [15:0] core_mv10; // Core output voltage, tenths of a millivolt
  logic [15:0] second_mv10; // Second output voltage, tenths of a millivolt
  // Any regulator not off needs the switching clock
  // The keep-running bit holds the PLL on even with every regulator off,
  // trading idle current for a start with no PLL lock time
  wire regs_on = (core_mode != buck_ctrl_pkg::MODE_OFF) ||
                 (second_mode != buck_ctrl_pkg::MODE_OFF);
  // Feedback divide of the crystal-referenced PLL chosen by the select bit
  // Both divides are whole-number ratios of the crystal reference, rounded down
  wire [7:0] next_pll_mult = SWITCH_FREQ_SELECT_I ? 8'(buck_ctrl_pkg::PLL_MULT_HIGH) :
                             8'(buck_ctrl_pkg::PLL_MULT_LOW);
  // Power good drops one cycle after a differing requested code appears
  // Compare against the requested code, not only the held target, so a new write
  // is seen at once; in a low power state the ramp alone decides
  wire next_power_good = core_at && (CORE_VOLTAGE_CODE_I == core_target ||
                         LP_STATE_I != buck_ctrl_pkg::LP_NONE);
  // Output registers; reset shows power good and the low switching rate
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      power_good <= 1'b1;
      pll_run <= 1'b0;
      pll_mult <= 8'(buck_ctrl_pkg::PLL_MULT_LOW);
      core_mv10 <= 16'h0000;
      second_mv10 <= 16'h0000;
    end else begin
      power_good <= next_power_good;
      pll_run <= PLL_KEEP_RUNNING_I | regs_on;
      pll_mult <= next_pll_mult;
      core_mv10 <= code_to_mv10(core_applied);
      second_mv10 <= code_to_mv10(second_applied);
    end
  end

  // Port assignments; all but the shared interrupt come straight from flip-flops
  assign CORE_MODE_O = core_mode;
  assign SECOND_MODE_O = second_mode;
  assign CORE_A_CODE_O = core_applied;
  assign CORE_B_CODE_O = core_applied;
  assign SECOND_CODE_O = second_applied;
  assign CORE_MV10_O = core_mv10;
  assign SECOND_MV10_O = second_mv10;
  assign CORE_POWER_GOOD_O = power_good;
  assign CORE_SINGLE_PHASE_O = single_phase;
  assign PLL_RUN_O = pll_run;
  assign PLL_MULT_O = pll_mult;
  // Cycle-by-cycle limiting while the detector is active
  // This follows the settled detect with no latching: the limit ends with the event
  assign CORE_CYCLE_LIMIT_O = core_oc;
  assign SECOND_CYCLE_LIMIT_O = second_oc;
  // Status flags and the shared interrupt, high while any flag is set
  assign CORE_OVERCURRENT_FLAG_O = core_flag;
  assign SECOND_BUCK_OVERCURRENT_FLAG_O = second_flag;
  assign SHORT_CIRCUIT_IRQ_O = core_flag | second_flag;
endmodule : buck_regulator_control

// >>> sim/buck_ctrl_props.sv
// Checker for the buck regulator control top, watching only its ports.
// Assumes one system clock and a synchronous active-high reset.
module buck_ctrl_props (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [1:0] LP_STATE_I,
  input wire logic [1:0] HOLD_STATE_MODE_SELECT_I,
  input wire logic [1:0] USER_OFF_MODE_SELECT_I,
  input wire logic SWITCH_FREQ_SELECT_I,
  input wire logic PLL_KEEP_RUNNING_I,
  input wire logic CORE_OC_I,
  input wire logic CORE_FLAG_CLEAR_I,
  input wire logic [1:0] CORE_MODE_O,
  input wire logic [1:0] SECOND_MODE_O,
  input wire logic [5:0] CORE_A_CODE_O,
  input wire logic [5:0] CORE_B_CODE_O,
  input wire logic CORE_POWER_GOOD_O,
  input wire logic PLL_RUN_O,
  input wire logic [7:0] PLL_MULT_O,
  input wire logic CORE_OVERCURRENT_FLAG_O,
  input wire logic SHORT_CIRCUIT_IRQ_O
);
  // All checks share the system clock and are quiet during reset
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  // Divide follows the select bit one cycle later
  property p_mult;
    1'b1 |=> PLL_MULT_O == ($past(SWITCH_FREQ_SELECT_I) ? 8'h7A : 8'h3D);
  endproperty
  a_mult: assert property (p_mult) else $error("pll divide wrong");
  property p_run; PLL_KEEP_RUNNING_I |=> PLL_RUN_O; endproperty
  a_run: assert property (p_run) else $error("pll stopped while kept running");
  // Both core phases always carry one code
  property p_ab; CORE_A_CODE_O == CORE_B_CODE_O; endproperty
  a_ab: assert property (p_ab) else $error("core phase codes differ");
  property p_oc;
    $rose(CORE_OC_I) |-> ##[2:4] (CORE_OVERCURRENT_FLAG_O && SHORT_CIRCUIT_IRQ_O);
  endproperty
  a_oc: assert property (p_oc) else $error("core fault not flagged");
  // Flag only drops on a clear pulse
  property p_stick;
    CORE_OVERCURRENT_FLAG_O && !CORE_FLAG_CLEAR_I |=> CORE_OVERCURRENT_FLAG_O;
  endproperty
  a_stick: assert property (p_stick) else $error("core flag dropped");
  // A stepping running core never shows power good
  property p_pg;
    !$stable(CORE_A_CODE_O) && $past(CORE_MODE_O) == 2'h2 |-> !CORE_POWER_GOOD_O;
  endproperty
  a_pg: assert property (p_pg) else $error("power good during ramp");
  property p_hold;
    $past(LP_STATE_I) == 2'h1 |->
      CORE_MODE_O == ($past(HOLD_STATE_MODE_SELECT_I[0]) ? 2'h1 : 2'h0);
  endproperty
  a_hold: assert property (p_hold) else $error("core hold mode wrong");
  property p_uoff;
    $past(LP_STATE_I) == 2'h2 |->
      SECOND_MODE_O == ($past(USER_OFF_MODE_SELECT_I[1]) ? 2'h1 : 2'h0);
  endproperty
  a_uoff: assert property (p_uoff) else $error("second user off mode wrong");
endmodule : buck_ctrl_props
bind buck_regulator_control buck_ctrl_props props (.*);

// >>> sim/host_model.sv
// Host side: services the short-circuit interrupt by pulsing flag clears.
// Assumes flags sampled on the system clock; slow_i delays the answer.
module host_model (
  input wire logic clk_i,
  input wire logic service_i,  // Servicing allowed
  input wire logic slow_i,     // Answer after 8 cycles instead of 1
  input wire logic irq_i,
  input wire logic core_flag_i,
  input wire logic second_flag_i,
  output logic core_clear_o,
  output logic second_clear_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clear each raised flag for one cycle after the interrupt is seen
  initial begin
    core_clear_o = 1'b0;
    second_clear_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (service_i && irq_i) begin
        repeat (slow_i ? 8 : 1) @(posedge clk_i);
        #1;
        core_clear_o = core_flag_i;
        second_clear_o = second_flag_i;
        @(posedge clk_i);
        #1;
        core_clear_o = 1'b0;
        second_clear_o = 1'b0;
      end
    end
  end
endmodule : host_model

// >>> sim/buck_regulator_control_tb.sv
// Self-checking bench for the buck regulator control top.
// Assumes RAMP_CYC of 2 and the host model servicing faults.
module buck_regulator_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic SYS_CLK_I, RESET_I, STARTUP_I, CORE_SLOT_I, SECOND_SLOT_I, CORE_ENABLE_I;
  logic SECOND_ENABLE_I, SWITCH_FREQ_SELECT_I, PLL_KEEP_RUNNING_I, CORE_PHASE_CONFIG_PIN_I;
  logic CORE_OC_I, SECOND_OC_I, CORE_FLAG_CLEAR_I, SECOND_FLAG_CLEAR_I, service, slow;
  logic [1:0] LP_STATE_I, HOLD_STATE_MODE_SELECT_I, USER_OFF_MODE_SELECT_I;
  logic [4:0] CORE_STANDBY_SETPOINT_I, SECOND_STANDBY_SETPOINT_I;
  logic [5:0] CORE_VOLTAGE_CODE_I, SECOND_BUCK_VOLTAGE_CODE_I, CORE_A_CODE_O, CORE_B_CODE_O;
  logic [5:0] SECOND_CODE_O;
  logic [1:0] CORE_MODE_O, SECOND_MODE_O;
  logic [15:0] CORE_MV10_O, SECOND_MV10_O;
  logic [7:0] PLL_MULT_O;
  logic CORE_POWER_GOOD_O, CORE_SINGLE_PHASE_O, PLL_RUN_O, CORE_CYCLE_LIMIT_O;
  logic SECOND_CYCLE_LIMIT_O, CORE_OVERCURRENT_FLAG_O, SECOND_BUCK_OVERCURRENT_FLAG_O;
  logic SHORT_CIRCUIT_IRQ_O;
  int miscompares = 0;
  int checked = 0;
  // Row: select, keep, core code, second code, divide, core and second output
  typedef struct packed {
    logic sel, keep;
    logic [5:0] c, s;
    logic [7:0] m;
    logic [15:0] vc, vs;
  } row_t;
  row_t rows [3] = '{'{1'b0, 1'b1, 6'h01, 6'h3F, 8'h3D, 16'h19E1, 16'h3827},
                     '{1'b1, 1'b0, 6'h3F, 6'h00, 8'h7A, 16'h3827, 16'h1964},
                     '{1'b0, 1'b0, 6'h20, 6'h20, 8'h3D, 16'h2904, 16'h2904}};
  buck_regulator_control #(.RAMP_CYC(2)) uut (.*);
  host_model host (.clk_i(SYS_CLK_I), .service_i(service), .slow_i(slow),
    .irq_i(SHORT_CIRCUIT_IRQ_O), .core_flag_i(CORE_OVERCURRENT_FLAG_O),
    .second_flag_i(SECOND_BUCK_OVERCURRENT_FLAG_O), .core_clear_o(CORE_FLAG_CLEAR_I),
    .second_clear_o(SECOND_FLAG_CLEAR_I));
  // 100 MHz clock
  initial begin
    SYS_CLK_I = 1'b0;
    forever #5 SYS_CLK_I = ~SYS_CLK_I;
  end
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK_I);
    #1;
  endtask : cyc
  // Bounded wait for the ramps to land; core is optional
  task automatic settle(input logic [5:0] c, input logic [5:0] s, input logic uc);
    int n = 0;
    while (!((!uc || CORE_A_CODE_O === c && CORE_POWER_GOOD_O === 1'b1) &&
             SECOND_CODE_O === s)) begin
      cyc(1);
      n++;
      if (n > 400) begin
        miscompares++;
        tally_and_finish();
      end
    end
    cyc(2);
  endtask : settle
  initial begin
    RESET_I = 1'b1;
    {STARTUP_I, CORE_SLOT_I, SECOND_SLOT_I, CORE_OC_I, SECOND_OC_I, service, slow} = '0;
    {CORE_ENABLE_I, SECOND_ENABLE_I, CORE_PHASE_CONFIG_PIN_I} = 3'h7;
    {LP_STATE_I, HOLD_STATE_MODE_SELECT_I, USER_OFF_MODE_SELECT_I} = '0;
    {CORE_STANDBY_SETPOINT_I, SECOND_STANDBY_SETPOINT_I, SWITCH_FREQ_SELECT_I} = '0;
    {CORE_VOLTAGE_CODE_I, SECOND_BUCK_VOLTAGE_CODE_I, PLL_KEEP_RUNNING_I} = '0;
    cyc(20);
    RESET_I = 1'b0;
    // Reset values
    check({CORE_MODE_O, SECOND_MODE_O, CORE_POWER_GOOD_O, CORE_SINGLE_PHASE_O, PLL_RUN_O,
           SHORT_CIRCUIT_IRQ_O, PLL_MULT_O}, 16'h0C3D);
    check({CORE_A_CODE_O, SECOND_CODE_O, CORE_MV10_O}, 28'h0000000);
    // Strap only follows the pin at a startup event
    for (int k = 0; k < 2; k++) begin
      CORE_PHASE_CONFIG_PIN_I = k[0];
      cyc(4);
      check(CORE_SINGLE_PHASE_O, !k[0]);
      STARTUP_I = 1'b1;
      cyc(1);
      STARTUP_I = 1'b0;
      cyc(2);
      check(CORE_SINGLE_PHASE_O, k[0]);
    end
    // Core then second fault with no servicing: flags stay set until slow servicing clears them
    CORE_OC_I = 1'b1;
    cyc(3);
    check(CORE_CYCLE_LIMIT_O, 1'b1);
    CORE_OC_I = 1'b0;
    cyc(8);
    check({CORE_OVERCURRENT_FLAG_O, SECOND_BUCK_OVERCURRENT_FLAG_O, SHORT_CIRCUIT_IRQ_O,
           CORE_CYCLE_LIMIT_O}, 4'hA);
    SECOND_OC_I = 1'b1;
    cyc(3);
    check(SECOND_CYCLE_LIMIT_O, 1'b1);
    SECOND_OC_I = 1'b0;
    cyc(1);
    check({CORE_OVERCURRENT_FLAG_O, SECOND_BUCK_OVERCURRENT_FLAG_O,
           SHORT_CIRCUIT_IRQ_O}, 3'h7);
    {service, slow} = 2'h3;
    cyc(30);
    check({CORE_OVERCURRENT_FLAG_O, SECOND_BUCK_OVERCURRENT_FLAG_O,
           SHORT_CIRCUIT_IRQ_O}, 3'h0);
    // Ordinary set points and switching rates
    foreach (rows[i]) begin
      {SWITCH_FREQ_SELECT_I, PLL_KEEP_RUNNING_I} = {rows[i].sel, rows[i].keep};
      CORE_VOLTAGE_CODE_I = rows[i].c;
      SECOND_BUCK_VOLTAGE_CODE_I = rows[i].s;
      cyc(2);
      check(CORE_POWER_GOOD_O, 1'b0);
      settle(rows[i].c, rows[i].s, 1'b1);
      check(CORE_B_CODE_O, rows[i].c);
      check(CORE_MV10_O, rows[i].vc);
      check(SECOND_MV10_O, rows[i].vs);
      check(PLL_MULT_O, rows[i].m);
    end
    // Memory hold with both regulators kept in PFM on standby points
    {CORE_STANDBY_SETPOINT_I, SECOND_STANDBY_SETPOINT_I} = {5'h1F, 5'h05};
    HOLD_STATE_MODE_SELECT_I = 2'h3;
    LP_STATE_I = 2'h1;
    cyc(2);
    check({CORE_MODE_O, SECOND_MODE_O}, 4'h5);
    settle(6'h1F, 6'h05, 1'b1);
    check(CORE_MV10_O, 16'h2887);
    // Leaving hold keeps settings until the core slot
    LP_STATE_I = 2'h0;
    cyc(10);
    check({CORE_MODE_O, CORE_A_CODE_O}, 8'h5F);
    CORE_SLOT_I = 1'b1;
    cyc(1);
    CORE_SLOT_I = 1'b0;
    cyc(1);
    check(CORE_MODE_O, 2'h2);
    settle(6'h20, 6'h05, 1'b1);
    // User off: core off, second in PFM on its new standby point
    SECOND_STANDBY_SETPOINT_I = 5'h0A;
    USER_OFF_MODE_SELECT_I = 2'h2;
    LP_STATE_I = 2'h2;
    cyc(2);
    check({CORE_MODE_O, SECOND_MODE_O}, 4'h1);
    settle(6'h00, 6'h0A, 1'b0);
    check(SECOND_MV10_O, 16'h1E46);
    // Both off: the PLL runs only when kept running
    USER_OFF_MODE_SELECT_I = 2'h0;
    cyc(3);
    check(PLL_RUN_O, 1'b0);
    PLL_KEEP_RUNNING_I = 1'b1;
    cyc(2);
    check(PLL_RUN_O, 1'b1);
    // Back to normal: regulators off through user off take normal settings at once
    CORE_ENABLE_I = 1'b0;
    LP_STATE_I = 2'h0;
    cyc(2);
    check({CORE_MODE_O, SECOND_MODE_O}, 4'h2);
    tally_and_finish();
  end
endmodule : buck_regulator_control_tb
